// >>> tcm_pkg.sv
// Package for the timer channel mode control block
package tcm_pkg;
  localparam int TCM_CNT_W = 16;
  // Byte offsets of the Wishbone register map
  localparam logic [3:0] TCM_ADDR_CSC = 4'h0;
  localparam logic [3:0] TCM_ADDR_VAL = 4'h4;
  localparam logic [3:0] TCM_ADDR_CTL = 4'h8;
  localparam logic [3:0] TCM_ADDR_STS = 4'hC;
  localparam logic [3:0] TCM_ADDR_MSK = 4'h0;
  // Field positions of channel_status_control
  localparam int TCM_BIT_FLAG = 7;
  localparam int TCM_BIT_IE = 6;
  localparam int TCM_BIT_MSU = 5;
  localparam int TCM_BIT_MSL = 4;
  localparam int TCM_BIT_ELH = 3;
  localparam int TCM_BIT_ELL = 2;
  // Reset values
  localparam logic [7:0] TCM_CSC_RST = 8'h00;
  localparam logic [15:0] TCM_VAL_RST = 16'h0000;
  // Edge/level codes
  localparam logic [1:0] TCM_EL_OFF = 2'h0;
  localparam logic [1:0] TCM_EL_01 = 2'h1;
  localparam logic [1:0] TCM_EL_10 = 2'h2;
  localparam logic [1:0] TCM_EL_11 = 2'h3;
  typedef enum logic [1:0] {
    TCM_MODE_CAPTURE, TCM_MODE_COMPARE, TCM_MODE_EPWM, TCM_MODE_CPWM
  } tcm_mode_e;
endpackage

// >>> tcm_pin_sync.sv
// Three-stage synchroniser with agreement filter for the channel pin
`timescale 1ns/100ps
module tcm_pin_sync
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tcm_sync_s;
  tcm_sync_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // A change counts once stages two and three agree
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;
endmodule

// >>> tcm_channel.sv
// Timer channel mode control with Wishbone register slave
// Notes on behaviour
// - capture edge on pin sets event flag
// - compare or edge PWM match sets flag
// - center PWM sets flag every match
// - interrupt while flag and enable set
// - flag clears after read then zero write
// - new event restarts clear sequence
// - writing one leaves flag; reset clears
// - enable bit readable, writable, reset clear
// - upper mode bit selects edge PWM
// - lower mode bit picks capture or compare
// - code zero disconnects pin from channel
// - capture edges rising, falling, or both
// - compare toggles, clears, sets, or software
// - edge PWM polarity from field code
// - center PWM polarity on up compare
// - center select forces center PWM everywhere
`timescale 1ns/100ps
module tcm_channel
  import tcm_pkg::*;
#(
  parameter int CNT_W = TCM_CNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer side
  input wire logic center_pwm_select,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic count_up,
  input wire logic count_tick,
  // Channel pin
  input wire logic chan_pin_in,
  output logic chan_pin_out,
  output logic chan_pin_oe,
  // Capture strobe and interrupt
  output logic capture_pulse,
  output logic chan_irq
);
  // Value writes pair two byte lanes, so the count must span both lanes
  if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 9 and 16");
  end

  typedef struct packed {
    logic flag;
    logic ie;
    logic msu;
    logic msl;
    logic [1:0] el;
    logic armed;
    logic pin_prev;
    logic pin_out;
    logic cap;
    logic [CNT_W-1:0] val;
    logic sts_evt;
    logic msk_evt;
    logic ack;
    logic [31:0] rdata;
  } tcm_state_s;
  tcm_state_s st_reg, st_next;

  logic pin_lvl;
  tcm_mode_e mode;
  logic rise, fall, edge_hit, match, event_hit, connected;
  logic wb_req, wr_csc, rd_csc;
  logic [7:0] csc_view;

  tcm_pin_sync u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(chan_pin_in),
    .level(pin_lvl)
  );

  always_comb begin
    // Mode decode, center select overriding the mode bits
    // center overrides
    if (center_pwm_select) begin
      mode = TCM_MODE_CPWM;
    end else if (st_reg.msu) begin
      mode = TCM_MODE_EPWM;
    end else if (st_reg.msl) begin
      mode = TCM_MODE_COMPARE;
    end else begin
      mode = TCM_MODE_CAPTURE;
    end
  end

  assign connected = (st_reg.el != TCM_EL_OFF);
  assign rise = pin_lvl & ~st_reg.pin_prev;
  assign fall = ~pin_lvl & st_reg.pin_prev;
  assign edge_hit = ((st_reg.el == TCM_EL_01) & rise)
                  | ((st_reg.el == TCM_EL_10) & fall)
                  | ((st_reg.el == TCM_EL_11) & (rise | fall));
  // Match is taken once per timer tick so a held count flags once
  assign match = count_tick & (counter_value == st_reg.val);

  always_comb begin
    event_hit = 1'b0;
    case (mode)
      TCM_MODE_CAPTURE: event_hit = edge_hit;
      TCM_MODE_COMPARE: event_hit = match;
      TCM_MODE_EPWM: event_hit = match;
      TCM_MODE_CPWM: event_hit = match;
      default: event_hit = 1'b0;
    endcase
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign wr_csc = wb_req & wb_we_i & (wb_adr_i == TCM_ADDR_CSC)
                & wb_sel_i[0];
  assign rd_csc = wb_req & ~wb_we_i & (wb_adr_i == TCM_ADDR_CSC);
  assign csc_view = {st_reg.flag, st_reg.ie, st_reg.msu, st_reg.msl,
                     st_reg.el, 2'b00};

  always_comb begin
    st_next = st_reg;
    st_next.pin_prev = pin_lvl;
    st_next.cap = 1'b0;
    st_next.ack = wb_req;

    // Register writes
    if (wr_csc) begin
      st_next.ie = wb_dat_i[TCM_BIT_IE];
      st_next.msu = wb_dat_i[TCM_BIT_MSU];
      st_next.msl = wb_dat_i[TCM_BIT_MSL];
      st_next.el = wb_dat_i[TCM_BIT_ELH:TCM_BIT_ELL];
      if (st_reg.armed && !wb_dat_i[TCM_BIT_FLAG]) begin
        st_next.flag = 1'b0;
      end
      st_next.armed = 1'b0;
    end else if (rd_csc && st_reg.flag) begin
      st_next.armed = 1'b1;
    end
    if (wb_req && wb_we_i && wb_adr_i == TCM_ADDR_VAL) begin
      if (wb_sel_i[0]) st_next.val[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) st_next.val[CNT_W-1:8] = wb_dat_i[CNT_W-1:8];
    end
    if (wb_req && wb_we_i && wb_adr_i == TCM_ADDR_STS && wb_sel_i[0]) begin
      if (wb_dat_i[0]) st_next.sts_evt = 1'b0;
    end
    if (wb_req && wb_we_i && wb_adr_i == TCM_ADDR_CTL && wb_sel_i[0]) begin
      st_next.msk_evt = wb_dat_i[0];
    end

    // Capture latches the counter
    if (mode == TCM_MODE_CAPTURE && connected && edge_hit) begin
      st_next.val = counter_value;
      st_next.cap = 1'b1;
    end

    // Events win over any clear in the same cycle
    if (event_hit) begin
      st_next.flag = 1'b1;
      st_next.sts_evt = 1'b1;
      st_next.armed = 1'b0;
    end

    // Pin drive
    if (match) begin
      case (mode)
        TCM_MODE_COMPARE: begin
          if (st_reg.el == TCM_EL_01) st_next.pin_out = ~st_reg.pin_out;
          else if (st_reg.el == TCM_EL_10) st_next.pin_out = 1'b0;
          else if (st_reg.el == TCM_EL_11) st_next.pin_out = 1'b1;
        end
        TCM_MODE_EPWM: st_next.pin_out = st_reg.el[0];
        TCM_MODE_CPWM: begin
          if (count_up) st_next.pin_out = st_reg.el[0];
          else st_next.pin_out = ~st_reg.el[0];
        end
        default: st_next.pin_out = st_reg.pin_out;
      endcase
    end
    // Period start restores the idle pulse level in edge PWM
    if (mode == TCM_MODE_EPWM && count_tick
        && counter_value == '0 && !match) begin
      st_next.pin_out = ~st_reg.el[0];
    end

    // Read data, unmapped reads return zero
    st_next.rdata = 32'h0000_0000;
    if (wb_adr_i == TCM_ADDR_CSC) begin
      st_next.rdata[7:0] = csc_view;
    end else if (wb_adr_i == TCM_ADDR_VAL) begin
      st_next.rdata[CNT_W-1:0] = st_reg.val;
    end else if (wb_adr_i == TCM_ADDR_CTL) begin
      st_next.rdata[0] = st_reg.msk_evt;
    end else if (wb_adr_i == TCM_ADDR_STS) begin
      st_next.rdata[0] = st_reg.sts_evt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;
  assign chan_pin_out = st_reg.pin_out;
  assign chan_pin_oe = connected & (mode != TCM_MODE_CAPTURE);
  assign capture_pulse = st_reg.cap;
  assign chan_irq = (st_reg.flag & st_reg.ie)
                  | (st_reg.sts_evt & st_reg.msk_evt);
endmodule

// >>> tcm_monitor.sv
// Port checker for the timer channel block
`timescale 1ns/100ps
module tcm_monitor
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Channel side
  input wire logic center_pwm_select,
  input wire logic chan_pin_oe,
  input wire logic capture_pulse,
  input wire logic chan_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic rda;
  logic csc;
  assign rda = wb_ack_o && !wb_we_i;
  assign csc = wb_adr_i == TCM_ADDR_CSC;
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_RST: assert property ($rose(arst_n) |-> !chan_irq && !chan_pin_oe)
    else $error("outputs set after reset");
  AST_IRQ: assert property (rda && csc && wb_dat_o[7:6] == 2'h3 |->
    ##[0:1] chan_irq) else $error("irq missing");
  AST_OE: assert property (wb_ack_o && wb_we_i && csc &&
    wb_dat_i[3:2] == 2'h0 |-> ##[1:2] !chan_pin_oe) else $error("pin held");
  AST_CAPOE: assert property (capture_pulse |-> !chan_pin_oe)
    else $error("capture while driving");
  AST_CPWM: assert property (center_pwm_select [*2] |-> !capture_pulse)
    else $error("capture in center mode");
  AST_CSCZ: assert property (rda && csc |-> wb_dat_o[31:8] == 24'h0 &&
    wb_dat_o[1:0] == 2'h0) else $error("reserved bits set");
  AST_UNMAP: assert property (rda && !csc && wb_adr_i != TCM_ADDR_VAL |->
    wb_dat_o[31:1] == 31'h0) else $error("unmapped read");
  cover property (capture_pulse);
  cover property (chan_irq);
  cover property (rda && wb_dat_o[7]);
endmodule
bind tcm_channel tcm_monitor i_tcm_monitor (.*);

// >>> tcm_pin_model.sv
// Pin partner: drives the channel pin while the block does not
`timescale 1ns/100ps
module tcm_pin_model (
  // Clock and request
  input wire logic sys_clk,
  input wire logic lvl,
  // Block drive
  input wire logic pin_out,
  input wire logic pin_oe,
  // Wire
  output logic pin
);
  logic drv = 1'b0;
  // level moves only on request, then holds
  always @(posedge sys_clk) drv <= lvl;
  assign pin = pin_oe ? pin_out : drv;
endmodule

// >>> tb.sv
// Self-checking bench for the timer channel block
`timescale 1ns/100ps
module tb;
  import tcm_pkg::*;
  logic sys_clk = 0, arst_n = 0, cs = 0, we = 0, cpwm = 0, tick = 0;
  logic lvl = 0, ack, pout, poe, cap, irq, pin, p, up = 1;
  logic [1:0] e;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, q, dout, d;
  logic [15:0] cnt = 0, v;
  int errors = 0, n_checks = 0, seed = 32'h0A1BF451;
  tcm_channel i_tcm_channel (.sys_clk, .arst_n, .wb_cyc_i(cs),
    .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack),
    .center_pwm_select(cpwm), .counter_value(cnt), .count_up(up),
    .count_tick(tick), .chan_pin_in(pin), .chan_pin_out(pout),
    .chan_pin_oe(poe), .capture_pulse(cap), .chan_irq(irq));
  tcm_pin_model i_tcm_pin_model (.sys_clk, .lvl, .pin_out(pout),
    .pin_oe(poe), .pin);
  initial forever #2 sys_clk = ~sys_clk;
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, g, x);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] x);
    int i;
    @(posedge sys_clk);
    cs <= 1;
    we <= w;
    adr <= a;
    wd <= x;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge sys_clk);
    q = dout;
    cs <= 0;
    if (i == 20) begin
      errors++;
      close_out();
    end
  endtask
  // Read arms the flag clear, the write completes it
  task automatic cfg(input logic [7:0] c);
    wb(TCM_ADDR_CSC, 0, 0);
    wb(TCM_ADDR_CSC, 1, {24'h0, c});
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] x);
    wb(a, 0, 0);
    chk(q, x);
  endtask
  // Long enough for the pin synchroniser to settle
  task automatic pin_to(input logic l);
    lvl <= l;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic match(input logic [15:0] m);
    cnt <= m;
    tick <= 1;
    @(posedge sys_clk);
    tick <= 0;
    repeat (3) @(posedge sys_clk);
  endtask
  function automatic logic cap_hit(input logic [1:0] c, input logic r);
    return r ? c[0] : c[1];
  endfunction
  function automatic logic oc_pin(input logic [1:0] c, input logic o);
    return c == TCM_EL_01 ? !o : c[0];
  endfunction
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1;
    rdc(TCM_ADDR_CSC, 0);
    repeat (3) begin
      d = $random(seed) & 32'hCC;
      wb(TCM_ADDR_CSC, 1, d);
      rdc(TCM_ADDR_CSC, d & 32'h4C);
    end
    cnt <= 16'($random(seed));
    for (int k = 1; k < 4; k++) begin
      e = 2'(k);
      cfg({4'h4, e, 2'h0});
      pin_to(1);
      rdc(TCM_ADDR_CSC, {24'h0, cap_hit(e, 1), 3'h4, e, 2'h0});
      chk(irq, cap_hit(e, 1));
      rdc(TCM_ADDR_VAL, {16'h0, cnt});
      cfg({4'h4, e, 2'h0});
      pin_to(0);
      rdc(TCM_ADDR_CSC, {24'h0, cap_hit(e, 0), 3'h4, e, 2'h0});
    end
    cfg(8'h00);
    wb(TCM_ADDR_CTL, 1, 1);
    chk(irq, 1);
    wb(TCM_ADDR_CTL, 1, 0);
    chk(irq, 0);
    wb(TCM_ADDR_STS, 1, 1);
    rdc(TCM_ADDR_STS, 0);
    // Odd value keeps the match away from count zero
    v = 16'($random(seed)) | 16'h0001;
    wb(TCM_ADDR_VAL, 1, {16'h0, v});
    for (int k = 0; k < 4; k++) begin
      e = 2'(k);
      cfg({4'h1, e, 2'h0});
      chk(poe, e != 2'h0);
      p = pout;
      match(v);
      rdc(TCM_ADDR_CSC, {24'h0, 4'h9, e, 2'h0});
      if (e != 2'h0) chk(pout, oc_pin(e, p));
    end
    wb(TCM_ADDR_CSC, 0, 0);
    match(v);
    wb(TCM_ADDR_CSC, 1, 32'h1C);
    rdc(TCM_ADDR_CSC, 32'h9C);
    cfg(8'h1C);
    rdc(TCM_ADDR_CSC, 32'h1C);
    cfg(8'h28);
    chk(poe, 1);
    match(v);
    chk(pout, 0);
    match(16'h0000);
    chk(pout, 1);
    cpwm <= 1;
    cfg(8'h0C);
    match(v);
    rdc(TCM_ADDR_CSC, 32'h8C);
    chk(poe, 1);
    chk(pout, 1);
    up <= 0;
    match(v);
    chk(pout, 0);
    rdc(TCM_ADDR_CSC, 32'h8C);
    rdc(4'h2, 0);
    close_out();
  end
endmodule
